// ### rtl/can_buf_consts.svh
`ifndef CAN_BUF_CONSTS_SVH
`define CAN_BUF_CONSTS_SVH
// buffers 0-2 dedicated tx, 3-4 dedicated rx, 5-10 programmable
`define NUM_BUF 11
`define NUM_BYTES 13
`define BUF_LAST 4'ha
`define PROG_FIRST 4'h5
// register index inside a buffer window and the module window
`define REG_LAST 4'hd
`define MOD_WIN 10
`define MOD_CTRL 4'h0
`define MOD_SEL 4'h1
`define MOD_IRQ 4'h2
`define MOD_STAT 4'h3
// buffer control word fields
`define C_PRIO 0
`define C_AUTO_REMOTE_REPLY_ENABLE 2
`define C_TRANSMIT_REQUEST_FLAG 3
`define C_ERR 4
`define C_LARB 5
`define C_ABT 6
`define C_DONE 7
`define C_DONE_IE 8
`define C_RX_IE 9
`define C_HIT 16
`define C_RTR 21
`define C_RXM 22
`define C_FULL 24
// module register fields
`define M_ABORT_ALL 4
`define M_MODE 6
`define I_INV 0
`define I_INV_IE 1
// frame image byte slots
`define B_STD_ID_LOW 1
`define B_DLC 4
`define STD_ID_LOW_IDENTIFIER_TYPE_FLAG 3
`define DLC_RTR 6
// reset values
`define MODE_RST 2'h0
`define SEL_RST 6'h0
// bus responses
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// ### rtl/can_buf_pkg.sv
package can_buf_pkg;
  typedef enum logic {TX_IDLE, TX_BUSY} tx_state_t;
  // frame image: std_id_high, std_id_low, ext_id_high, ext_id_low, dlc, data0..data7
  typedef struct packed {
    logic ext;
    logic rtr;
    logic [12:0][7:0] regs;
  } can_frame_t;
  typedef struct packed {
    logic ok;
    logic lost;
    logic err;
  } tx_outcome_t;
  typedef struct packed {
    logic hit;
    logic [3:0] target;
    logic [4:0] filter;
    logic filter_ext;
    logic mask_restrict;
    logic error;
  } rx_match_t;
endpackage : can_buf_pkg

// ### rtl/can_msg_buffers.sv
// Behaviour
// - modes 1/2, tx-selected buffer with auto reply sets its own request on remote frame
// - while a buffer's request is set, firmware writes to it are dropped
// - setting a transmit request clears aborted, lost-arbitration and error flags
// - request only marks ready; sending starts once the bus is available
// - success clears request, sets done flag, interrupts if enabled
// - failure keeps request; error sets error and invalid flags, loss sets lost flag
// - clearing a request aborts that buffer; abort-all aborts every pending buffer
// - unstarted or failed frames abort with aborted flag; completed frames do not
// - firmware cannot cancel a pending abort; only hardware or reset clears it
// - before each frame the highest priority wins; ties go to higher number
// - two-bit priority per tx buffer, 11 highest and 00 lowest
// - assembled frame is copied whole into the target receive buffer
// - delivery sets full flag, interrupts if enabled; a full buffer takes no frame
// - delivery records filter hit, four bits mode 0, five bits modes 1/2, and rtr
// - received identifier-type flag is cleared for standard, set for extended
// - receive mode 00 follows filters; mode 0 settings 01/10 restrict type
// - modes 1/2 mask type bit restricts reception to one identifier type
// - receive mode 11 accepts everything, including partial erroneous frames
// - modes 1/2 frames hitting a tx-configured buffer are discarded
// - reset starts in functional mode 0 with only dedicated buffers
// - programmable buffers reset to receive until their tx select is set
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "can_buf_consts.svh"
module can_msg_buffers
  import can_buf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic bus_idle,
  output logic tx_valid,
  output can_frame_t tx_frame,
  input wire tx_outcome_t tx_result,
  input wire logic rx_valid,
  input wire can_frame_t rx_frame,
  input wire rx_match_t rx_match,
  output logic irq
);
  logic [7:0] mem [0:`NUM_BUF-1][0:`NUM_BYTES-1];
  logic [`NUM_BUF-1:0] transmit_request_flag, abt_req, aborted, larb, err, done_flag, done_ie, rtr_en;
  logic [`NUM_BUF-1:0] full, rx_ie, rtr_rx, is_tx, exist, acc_all, ready, hi;
  logic [`NUM_BUF-1:0][1:0] prio, rx_mode_select;
  logic [`NUM_BUF-1:0][4:0] hit;
  logic [1:0] mode;
  logic abort_all, inv_flag, inv_ie;
  logic [5:0] tx_sel;
  tx_state_t state;
  logic [3:0] cur, best, rx_tgt;
  logic any, fin, rx_have, type_ok, deliver, auto_rr;
  logic [11:0] waddr;
  logic [31:0] wdat, rd_word;
  logic [3:0] wstb, w_buf, w_reg, rb, rr;
  logic wr_en, buf_wr, wr_ok, byte_wr, mod_wr, rd_ok;

  // write path decode
  assign w_buf = waddr[9:6];
  assign w_reg = waddr[5:2];
  assign wr_en = !awready && !wready && !bvalid;
  assign buf_wr = !waddr[`MOD_WIN] && w_buf <= `BUF_LAST && w_reg <= `REG_LAST;
  assign wr_ok = buf_wr || (waddr[`MOD_WIN] && waddr[9:2] <= {4'h0, `MOD_STAT});
  assign byte_wr = wr_en && buf_wr && w_reg != 4'h0 && wstb[0] && !transmit_request_flag[w_buf];
  assign mod_wr = wr_en && waddr[`MOD_WIN] && w_buf == 4'h0 && wstb[0];
  assign fin = state == TX_BUSY && (tx_result.ok || tx_result.lost || tx_result.err);
  assign ready = transmit_request_flag & is_tx & exist & ~abt_req;

  // axi write channel: address and data in either order, one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
      waddr <= 12'h000;
      wdat <= 32'h0000_0000;
      wstb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        waddr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wdat <= wdata;
        wstb <= wstrb;
      end
      if (wr_en) begin
        bvalid <= 1'b1;
        bresp <= wr_ok ? `RESP_OK : `RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read data mux
  assign rb = araddr[9:6];
  assign rr = araddr[5:2];
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b0;
    if (araddr[`MOD_WIN]) begin
      rd_ok = araddr[9:2] <= {4'h0, `MOD_STAT};
      case (rr)
        `MOD_CTRL: begin
          rd_word[`M_MODE +: 2] = mode;
          rd_word[`M_ABORT_ALL] = abort_all;
        end
        `MOD_SEL: rd_word[5:0] = tx_sel;
        `MOD_IRQ: begin
          rd_word[`I_INV] = inv_flag;
          rd_word[`I_INV_IE] = inv_ie;
        end
        `MOD_STAT: rd_word[7:0] = {cur, 3'h0, state == TX_BUSY};
        default: rd_word = 32'h0000_0000;
      endcase
    end else if (rb <= `BUF_LAST && rr <= `REG_LAST) begin
      rd_ok = 1'b1;
      if (rr == 4'h0) begin
        rd_word[`C_PRIO +: 2] = prio[rb];
        rd_word[`C_AUTO_REMOTE_REPLY_ENABLE] = rtr_en[rb];
        rd_word[`C_TRANSMIT_REQUEST_FLAG] = transmit_request_flag[rb];
        rd_word[`C_ERR] = err[rb];
        rd_word[`C_LARB] = larb[rb];
        rd_word[`C_ABT] = aborted[rb];
        rd_word[`C_DONE] = done_flag[rb];
        rd_word[`C_DONE_IE] = done_ie[rb];
        rd_word[`C_RX_IE] = rx_ie[rb];
        rd_word[`C_HIT +: 5] = hit[rb];
        rd_word[`C_RTR] = rtr_rx[rb];
        rd_word[`C_RXM +: 2] = rx_mode_select[rb];
        rd_word[`C_FULL] = full[rb];
      end else begin
        rd_word[7:0] = mem[rb][rr - 4'h1];
      end
    end
  end

  // axi read channel: data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OK;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_ok ? rd_word : 32'h0000_0000;
        rresp <= rd_ok ? `RESP_OK : `RESP_ERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // module control, direction select and invalid-message flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= `MODE_RST;
      abort_all <= 1'b0;
      tx_sel <= `SEL_RST;
      inv_flag <= 1'b0;
      inv_ie <= 1'b0;
    end else begin
      if (abort_all && !(|transmit_request_flag)) abort_all <= 1'b0;
      if (mod_wr && w_reg == `MOD_CTRL) begin
        mode <= wdat[`M_MODE +: 2];
        if (wdat[`M_ABORT_ALL]) abort_all <= 1'b1;
      end
      if (mod_wr && w_reg == `MOD_SEL) tx_sel <= wdat[5:0];
      if (mod_wr && w_reg == `MOD_IRQ) begin
        inv_ie <= wdat[`I_INV_IE];
        if (!wdat[`I_INV]) inv_flag <= 1'b0;
      end
      if (fin && tx_result.err) inv_flag <= 1'b1;
    end
  end

  // receive target: filter's buffer, else lowest accept-all receiver
  always_comb begin
    rx_tgt = rx_match.target <= `BUF_LAST ? rx_match.target : 4'h0;
    rx_have = rx_match.hit && rx_match.target <= `BUF_LAST;
    if (!rx_match.hit) begin
      for (int i = `NUM_BUF - 1; i >= 3; i--) begin
        if (exist[i] && !is_tx[i] && acc_all[i]) begin
          rx_tgt = 4'(i);
          rx_have = 1'b1;
        end
      end
    end
  end

  // identifier type gate
  always_comb begin
    if (mode == 2'h0) begin
      type_ok = rx_match.filter_ext == rx_frame.ext && (rx_mode_select[rx_tgt] == 2'h0 ||
        (rx_mode_select[rx_tgt] == 2'h1 && !rx_frame.ext) || (rx_mode_select[rx_tgt] == 2'h2 && rx_frame.ext));
    end else begin
      type_ok = !rx_match.mask_restrict || rx_match.filter_ext == rx_frame.ext;
    end
  end

  // deliver to a free receiver; tx-configured targets only feed auto reply
  assign deliver = rx_valid && rx_have && exist[rx_tgt] && !is_tx[rx_tgt] && !full[rx_tgt] &&
    (acc_all[rx_tgt] || (rx_match.hit && !rx_match.error && type_ok));
  assign auto_rr = rx_valid && rx_have && rx_match.hit && !rx_match.error &&
    rx_tgt >= `PROG_FIRST && is_tx[rx_tgt] && rtr_en[rx_tgt] && rx_frame.rtr &&
    !transmit_request_flag[rx_tgt];

  // buffer contents: receive copy wins over a colliding firmware write
  always_ff @(posedge aclk) begin
    if (deliver) begin
      for (int i = 0; i < `NUM_BYTES; i++) begin
        mem[rx_tgt][i] <= rx_frame.regs[i];
      end
      mem[rx_tgt][`B_STD_ID_LOW][`STD_ID_LOW_IDENTIFIER_TYPE_FLAG] <= rx_frame.ext;
    end
    if (byte_wr && !(deliver && rx_tgt == w_buf)) mem[w_buf][w_reg - 4'h1] <= wdat[7:0];
  end

  tx_prio_pick u_pick (
    .ready(ready),
    .prio(prio),
    .any(any),
    .best(best)
  );

  // transmit sequencer: launch best ready buffer when the bus is free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= TX_IDLE;
      tx_valid <= 1'b0;
      cur <= 4'h0;
      tx_frame <= '0;
    end else begin
      case (state)
        TX_IDLE: begin
          if (bus_idle && any) begin
            state <= TX_BUSY;
            tx_valid <= 1'b1;
            cur <= best;
            for (int i = 0; i < `NUM_BYTES; i++) begin
              tx_frame.regs[i] <= mem[best][i];
            end
            tx_frame.ext <= mem[best][`B_STD_ID_LOW][`STD_ID_LOW_IDENTIFIER_TYPE_FLAG];
            tx_frame.rtr <= mem[best][`B_DLC][`DLC_RTR];
          end
        end
        TX_BUSY: begin
          if (fin) begin
            state <= TX_IDLE;
            tx_valid <= 1'b0;
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  // interrupt line from done, receive and invalid-message flags
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(done_flag & done_ie) || (inv_flag && inv_ie) ||
      |(full & rx_ie & ~is_tx & exist);
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  for (genvar b = 0; b < `NUM_BUF; b++) begin : g_buf
    localparam logic [3:0] ID = 4'(b);
    logic ctl_wr, abort_wr;
    assign ctl_wr = wr_en && buf_wr && w_buf == ID && w_reg == 4'h0 && !transmit_request_flag[b];
    assign abort_wr = wr_en && buf_wr && w_buf == ID && w_reg == 4'h0 && wstb[0] &&
      transmit_request_flag[b] && !wdat[`C_TRANSMIT_REQUEST_FLAG];
    if (b < 3) begin : g_dtx
      assign is_tx[b] = 1'b1;
      assign exist[b] = 1'b1;
    end else if (b < 5) begin : g_drx
      assign is_tx[b] = 1'b0;
      assign exist[b] = 1'b1;
    end else begin : g_prog
      assign is_tx[b] = mode != 2'h0 && tx_sel[b-5];
      assign exist[b] = mode != 2'h0;
    end
    assign acc_all[b] = mode == 2'h0 ? rx_mode_select[b] == 2'h3 : rx_mode_select[b][1];
    assign hi[b] = ready[b] && (prio[b] > prio[best] || (prio[b] == prio[best] && ID > best));

    // transmit control and status
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        transmit_request_flag[b] <= 1'b0;
        abt_req[b] <= 1'b0;
        aborted[b] <= 1'b0;
        larb[b] <= 1'b0;
        err[b] <= 1'b0;
        done_flag[b] <= 1'b0;
        done_ie[b] <= 1'b0;
        rtr_en[b] <= 1'b0;
        prio[b] <= 2'h0;
      end else begin
        if (ctl_wr && wstb[0]) begin
          prio[b] <= wdat[`C_PRIO +: 2];
          rtr_en[b] <= wdat[`C_AUTO_REMOTE_REPLY_ENABLE];
          if (!wdat[`C_DONE]) done_flag[b] <= 1'b0;
          if (wdat[`C_TRANSMIT_REQUEST_FLAG] && is_tx[b]) begin
            transmit_request_flag[b] <= 1'b1;
            aborted[b] <= 1'b0;
            larb[b] <= 1'b0;
            err[b] <= 1'b0;
          end
        end
        if (ctl_wr && wstb[1]) done_ie[b] <= wdat[`C_DONE_IE];
        if (auto_rr && rx_tgt == ID) begin
          transmit_request_flag[b] <= 1'b1;
          aborted[b] <= 1'b0;
          larb[b] <= 1'b0;
          err[b] <= 1'b0;
        end
        if ((abort_wr || abort_all) && transmit_request_flag[b]) abt_req[b] <= 1'b1;
        if (abt_req[b] && !(state == TX_BUSY && cur == ID)) begin
          transmit_request_flag[b] <= 1'b0;
          aborted[b] <= 1'b1;
          abt_req[b] <= 1'b0;
        end
        if (fin && cur == ID) begin
          if (tx_result.ok) begin
            transmit_request_flag[b] <= 1'b0;
            done_flag[b] <= 1'b1;
            abt_req[b] <= 1'b0;
          end else begin
            larb[b] <= larb[b] | tx_result.lost;
            err[b] <= err[b] | tx_result.err;
            if (abt_req[b]) begin
              transmit_request_flag[b] <= 1'b0;
              aborted[b] <= 1'b1;
              abt_req[b] <= 1'b0;
            end
          end
        end
      end
    end

    // receive control and status
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        full[b] <= 1'b0;
        rx_ie[b] <= 1'b0;
        rx_mode_select[b] <= 2'h0;
        hit[b] <= 5'h00;
        rtr_rx[b] <= 1'b0;
      end else begin
        if (ctl_wr && wstb[1]) rx_ie[b] <= wdat[`C_RX_IE];
        if (ctl_wr && wstb[2]) rx_mode_select[b] <= wdat[`C_RXM +: 2];
        if (ctl_wr && wstb[3] && !wdat[`C_FULL]) full[b] <= 1'b0;
        if (deliver && rx_tgt == ID) begin
          full[b] <= 1'b1;
          hit[b] <= mode == 2'h0 ? {1'b0, rx_match.filter[3:0]} : rx_match.filter;
          rtr_rx[b] <= rx_frame.rtr;
        end
      end
    end

    a_req_clears_flags: assert property ($rose(transmit_request_flag[b]) |-> !aborted[b] && !larb[b] && !err[b])
      else $error("request set with stale flags");
    a_abort_idle_buf: assert property (abt_req[b] && !(state == TX_BUSY && cur == ID)
      |=> !transmit_request_flag[b] && aborted[b]) else $error("idle abort not processed");
    a_full_lockout: assert property (full[b] |=> $stable(hit[b]) && $stable(rtr_rx[b]))
      else $error("full buffer reloaded");
  end

  a_auto_reply_set: assert property (auto_rr |=> transmit_request_flag[$past(rx_tgt)])
    else $error("auto reply did not queue");
  a_start_needs_bus: assert property ($rose(tx_valid) |-> $past(bus_idle) && $past(any))
    else $error("launch without free bus");
  a_done_clears_req: assert property (fin && tx_result.ok
    |=> !transmit_request_flag[$past(cur)] && done_flag[$past(cur)]) else $error("success not recorded");
  a_fail_keeps_req: assert property (fin && tx_result.err && !abt_req[cur]
    |=> transmit_request_flag[$past(cur)] && err[$past(cur)] && inv_flag)
    else $error("error handling wrong");
  a_abort_all_holds: assert property (abort_all && (|transmit_request_flag) |=> abort_all)
    else $error("abort-all dropped early");
  a_pick_highest: assert property (state == TX_IDLE && bus_idle && any |-> !(|hi))
    else $error("lower priority buffer launched");
  a_identifier_type_flag_copied: assert property (deliver |=> mem[$past(rx_tgt)][`B_STD_ID_LOW][`STD_ID_LOW_IDENTIFIER_TYPE_FLAG]
    == $past(rx_frame.ext)) else $error("identifier type not stored");

  c_auto_reply: cover property (auto_rr ##[1:50] fin);
  c_lost_arb: cover property (fin && tx_result.lost);
  c_deliver: cover property (deliver ##1 irq);
  c_abort_all: cover property (abort_all && state == TX_BUSY);
endmodule : can_msg_buffers

// ### rtl/tx_prio_pick.sv
`timescale 1ns/1ps
`include "can_buf_consts.svh"
module tx_prio_pick
  import can_buf_pkg::*;
(
  input wire logic [`NUM_BUF-1:0] ready,
  input wire logic [`NUM_BUF-1:0][1:0] prio,
  output logic any,
  output logic [3:0] best
);
  logic [1:0] best_p;

  // ascending scan with >= lets the higher buffer number win a tie
  always_comb begin
    any = 1'b0;
    best = 4'h0;
    best_p = 2'h0;
    for (int i = 0; i < `NUM_BUF; i++) begin
      if (ready[i] && (!any || prio[i] >= best_p)) begin
        any = 1'b1;
        best = 4'(i);
        best_p = prio[i];
      end
    end
  end
endmodule : tx_prio_pick

// ### test/can_bus_node.sv
`timescale 1ns/1ps
// far-side protocol engine: answers each launch and delivers assembled frames
module can_bus_node
  import can_buf_pkg::*;
(
  input wire logic aclk,
  input wire logic tx_valid,
  input wire can_frame_t tx_frame,
  output logic bus_idle,
  output tx_outcome_t tx_result,
  output logic rx_valid,
  output can_frame_t rx_frame,
  output rx_match_t rx_match
);
  logic idle_en = 1'b0;
  logic [1:0] outcome = 2'h0; // 0 ok, 1 lost, 2 error
  int delay = 1;
  // mask restricts the type and the linked filter holds the other type
  logic type_clash = 1'b0;
  logic [7:0] sent[$];
  // the bus is free only while no own frame is on it
  assign bus_idle = idle_en & ~tx_valid;
  // one outcome pulse per launch, after a prompt or a slow frame
  initial begin
    tx_result = '0;
    forever begin
      @(posedge aclk);
      if (tx_valid) begin
        sent.push_back(tx_frame.regs[0]);
        repeat (delay) @(posedge aclk);
        tx_result <= (outcome == 2'h0) ? 3'b100 : (outcome == 2'h1) ? 3'b010 : 3'b001;
        @(posedge aclk);
        tx_result <= '0;
      end
    end
  end
  // idle receive lines
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
    rx_match = '0;
  end
  // one assembled frame as a single-cycle pulse; payload scrambled afterwards
  task automatic send_rx(input logic ext, input logic rtr, input logic [3:0] tgt,
      input logic [4:0] flt, input logic hit, input logic err, input logic [7:0] seed);
    @(posedge aclk);
    for (int k = 0; k < 13; k++) rx_frame.regs[k] <= seed + 8'(k);
    rx_frame.ext <= ext;
    rx_frame.rtr <= rtr;
    rx_match <= {hit, tgt, flt, ext ^ type_clash, type_clash, err};
    rx_valid <= 1'b1;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame;
  endtask : send_rx
endmodule : can_bus_node

// ### test/can_message_buffer_txrx_control_test.sv
`timescale 1ns/1ps
module can_message_buffer_txrx_control_test
  import can_buf_pkg::*;
;
  logic aclk;
  logic aresetn = 1'b0;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, bus_idle, tx_valid, rx_valid, irq;
  logic [1:0] bresp, rresp;
  can_frame_t tx_frame, rx_frame;
  tx_outcome_t tx_result;
  rx_match_t rx_match;
  int fail_count = 0;
  int compares = 0;
  logic [1:0] last_bresp;

  can_msg_buffers dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .bus_idle, .tx_valid, .tx_frame, .tx_result, .rx_valid,
    .rx_frame, .rx_match, .irq);
  can_bus_node partner (.aclk, .tx_valid, .tx_frame, .bus_idle, .tx_result, .rx_valid,
    .rx_frame, .rx_match);

  // clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic close_out();
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // write: address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      last_bresp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : rd

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk_word(d & m, e);
  endtask : rdc

  // wait for n launches and the link to fall quiet
  task automatic wait_tx(input int n);
    while (partner.sent.size() < n || tx_valid) @(posedge aclk);
    repeat (2) @(posedge aclk);
  endtask : wait_tx

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdc(12'h400, 32'hc0, 32'h0);
    rdc(12'h404, 32'h3f, 32'h0);
    rd(12'h2c0, d, r);
    chk_word({30'h0, r}, 32'h2);
    chk_word(d, 32'h0);
    wr(12'h2c0, 32'h0, 4'h1);
    chk_word({30'h0, last_bresp}, 32'h2);
    wr(12'h404, 32'h0, 4'h1);
    chk_word({30'h0, last_bresp}, 32'h0);
  endtask : t_reset

  task automatic t_prio();
    partner.idle_en <= 1'b0;
    for (int n = 0; n < 3; n++) wr(12'(n * 64 + 4), 32'h10 + n, 4'h1);
    wr(12'h000, 32'h109, 4'h3);
    wr(12'h040, 32'h10b, 4'h3);
    wr(12'h080, 32'h10b, 4'h3);
    repeat (4) @(posedge aclk);
    chk_word(32'(partner.sent.size()), 32'h0);
    partner.idle_en <= 1'b1;
    wait_tx(3);
    for (int n = 0; n < 3; n++) chk_word(32'(partner.sent[n]), 32'h12 - n);
    rdc(12'h000, 32'h88, 32'h80);
    chk_bit(irq, 1'b1);
    for (int n = 0; n < 3; n++) wr(12'(n * 64), 32'h0, 4'h1);
    repeat (3) @(posedge aclk);
    chk_bit(irq, 1'b0);
  endtask : t_prio

  task automatic t_fail();
    partner.outcome <= 2'h1;
    partner.delay <= 20;
    partner.sent.delete();
    wr(12'h004, 32'h20, 4'h1);
    wr(12'h000, 32'h08, 4'h1);
    wait_tx(2);
    rdc(12'h000, 32'h28, 32'h28);
    wr(12'h004, 32'h99, 4'h1);
    rdc(12'h004, 32'hff, 32'h20);
    partner.outcome <= 2'h2;
    wait_tx(4);
    rdc(12'h000, 32'h18, 32'h18);
    rdc(12'h408, 32'h1, 32'h1);
    wr(12'h000, 32'h00, 4'h1);
    wait_tx(0);
    rdc(12'h000, 32'h48, 32'h40);
    wr(12'h000, 32'h00, 4'h1);
    rdc(12'h000, 32'h40, 32'h40);
    partner.outcome <= 2'h0;
    partner.delay <= 1;
    partner.sent.delete();
    wr(12'h000, 32'h08, 4'h1);
    wait_tx(1);
    rdc(12'h000, 32'hf8, 32'h80);
    wr(12'h408, 32'h0, 4'h1);
  endtask : t_fail

  task automatic t_abort_all();
    partner.outcome <= 2'h1;
    partner.delay <= 20;
    partner.sent.delete();
    wr(12'h000, 32'h08, 4'h1);
    wr(12'h040, 32'h08, 4'h1);
    wait_tx(1);
    wr(12'h400, 32'h10, 4'h1);
    wr(12'h400, 32'h00, 4'h1);
    wait_tx(0);
    rdc(12'h000, 32'h48, 32'h40);
    rdc(12'h040, 32'h48, 32'h40);
    partner.outcome <= 2'h0;
    partner.delay <= 1;
  endtask : t_abort_all

  task automatic t_rx();
    logic [1:0] rx_mode_select[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
    logic ext_t[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic hit_t[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic err_t[5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    logic exp_t[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    wr(12'h0c0, 32'h200, 4'h2);
    partner.send_rx(1'b1, 1'b0, 4'h3, 5'h2, 1'b1, 1'b0, 8'h30);
    repeat (2) @(posedge aclk);
    chk_bit(irq, 1'b1);
    rdc(12'h0c0, 32'h013f_0000, 32'h0102_0000);
    rdc(12'h0c8, 32'hff, 32'h39);
    rdc(12'h0f4, 32'hff, 32'h3c);
    partner.send_rx(1'b0, 1'b0, 4'h3, 5'h2, 1'b1, 1'b0, 8'h50);
    rdc(12'h0f4, 32'hff, 32'h3c);
    for (int i = 0; i < 5; i++) begin
      wr(12'h0c0, {8'h0, rx_mode_select[i], 22'h0}, 4'hc);
      partner.send_rx(ext_t[i], 1'b1, 4'h3, 5'h4, hit_t[i], err_t[i], 8'h08);
      rdc(12'h0c0, 32'h0120_0000, {7'h0, exp_t[i], 2'b0, 1'b1, 21'h0});
    end
    rdc(12'h0c8, 32'hff, 32'h01);
    rdc(12'h0f4, 32'hff, 32'h14);
    wr(12'h0c0, 32'h0, 4'hc);
  endtask : t_rx

  task automatic t_auto();
    partner.send_rx(1'b0, 1'b0, 4'h6, 5'h1, 1'b1, 1'b0, 8'h40);
    rdc(12'h180, 32'h0100_0000, 32'h0);
    wr(12'h400, 32'h40, 4'h1);
    partner.send_rx(1'b0, 1'b0, 4'h6, 5'h13, 1'b1, 1'b0, 8'h40);
    rdc(12'h180, 32'h011f_0000, 32'h0113_0000);
    wr(12'h180, 32'h0, 4'h8);
    partner.type_clash <= 1'b1;
    partner.send_rx(1'b1, 1'b0, 4'h6, 5'h2, 1'b1, 1'b0, 8'h40);
    rdc(12'h180, 32'h0100_0000, 32'h0);
    partner.type_clash <= 1'b0;
    wr(12'h404, 32'h01, 4'h1);
    wr(12'h144, 32'h66, 4'h1);
    wr(12'h140, 32'h104, 4'h3);
    partner.sent.delete();
    partner.send_rx(1'b0, 1'b1, 4'h5, 5'h3, 1'b1, 1'b0, 8'h77);
    wait_tx(1);
    chk_word(32'(partner.sent[0]), 32'h66);
    rdc(12'h140, 32'h0100_0088, 32'h80);
  endtask : t_auto

  // main sequence
  initial begin
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    wstrb = 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_prio();
    t_fail();
    t_abort_all();
    t_rx();
    t_auto();
    close_out();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    close_out();
  end
endmodule : can_message_buffer_txrx_control_test
